// ==== bmc_pkg.sv ====
// Package with register map, field positions and reset values of the bus match comparator block.
package bmc_pkg;

	// Register byte addresses on the APB side.
	localparam logic [11:0] BMC_OFF_A_DATA   = 12'h118;
	localparam logic [11:0] BMC_OFF_A_MASK   = 12'h11c;
	localparam logic [11:0] BMC_OFF_B_CTRL   = 12'h120;
	localparam logic [11:0] BMC_OFF_B_ADDR   = 12'h124;
	localparam logic [11:0] BMC_OFF_STATUS   = 12'h128;
	localparam logic [11:0] BMC_OFF_CLEAR    = 12'h12c;
	localparam logic [11:0] BMC_OFF_ENABLE   = 12'h130;

	// Comparator control field positions.
	localparam int unsigned BMC_CTL_INSTRUCTION_SELECT     = 5;
	localparam int unsigned BMC_CTL_RWV      = 3;
	localparam int unsigned BMC_CTL_RWE      = 2;
	localparam int unsigned BMC_CTL_EN       = 0;
	localparam logic [7:0]  BMC_CTL_WMASK    = 8'h2d;

	// Event bit positions in the status, clear and enable registers.
	localparam int unsigned BMC_EV_A_DATA    = 0;
	localparam int unsigned BMC_EV_B_MATCH   = 1;
	localparam int unsigned BMC_EV_REFUSED   = 2;
	localparam int unsigned BMC_EV_NUM       = 3;

	// Values after reset.
	localparam logic [31:0] BMC_RST_A_DATA   = 32'h0000_0000;
	localparam logic [31:0] BMC_RST_A_MASK   = 32'h0000_0000;
	localparam logic [7:0]  BMC_RST_B_CTRL   = 8'h00;
	localparam logic [23:0] BMC_RST_B_ADDR   = 24'h00_0000;
	localparam logic [2:0]  BMC_RST_EVENTS   = 3'h0;

	// Whole state of the block, registered in one process.
	typedef struct packed {
		logic [31:0] a_data;
		logic [31:0] a_mask;
		logic [7:0]  b_ctrl;
		logic [23:0] b_addr;
		logic [2:0]  status;
		logic [2:0]  irq_en;
		logic        match_a;
		logic        match_b;
		logic [31:0] rdata;
		logic        err;
	} bmc_state_t;

endpackage : bmc_pkg

// ==== bmc_bus_match_comparator_regs.sv ====
// Comparator A data value and mask, comparator B control and address, with APB access and events.
`timescale 1ns/100ps

// Notes on behaviour
// - Each comparator A data value bit is the level the matching data bus bit must have.
// - A data value bit takes part in the comparison only when its mask bit is one.
// - A mask bit of zero leaves its data bit out of the comparison and a one includes it.
// - The data value is byte accessible with bits 31 to 24 at the lowest address.
// - The data mask is byte accessible with its most significant byte at the lowest address.
// - All registers read at any time and writes to the comparator registers are ignored while the unit is armed.
// - Comparator B instruction select at bit 5 compares the program counter when one.
// - Access type enable at bit 2 puts the bus direction into the comparison unless instruction_select is set.
// - Access type value at bit 3 selects writes at zero and reads at one.
// - With access type enabled a match needs the direction signal to equal the value bit.
// - Comparator B gives no match unless its enable bit at position 0 is set.
// - In range mode comparator B takes its configuration from the comparator A control.
// - Each of the 24 comparator B address bits gives the level of its address bus bit.
// - The comparator B control resets to zero and its bits 7, 6, 4 and 1 read as zero.
// - The comparators work only while the arm flag is set.
// - With instruction select set only the exact opcode address is matched.
module bmc_bus_match_comparator_regs
	import bmc_pkg::*;
(
	// Clock, reset and clock enable.
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pclk_en,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Controls from the rest of the breakpoint unit.
	input  wire logic        breakpoint_unit_arm,
	input  wire logic        range_pair_select,
	input  wire logic [7:0]  comp_a_control,
	// Processor core bus.
	input  wire logic        core_acc_valid,
	input  wire logic [23:0] core_addr,
	input  wire logic [31:0] core_data,
	input  wire logic        core_rw,
	input  wire logic        core_pc_valid,
	input  wire logic [23:0] core_pc,
	// Match and interrupt outputs.
	output logic             comp_a_data_match,
	output logic             comp_b_match,
	output logic             irq
);

	// Reorders the bytes so the register byte at the lowest address rides on lane 0.
	function automatic logic [31:0] bmc_swap(input logic [31:0] w);
		bmc_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : bmc_swap

	// Merges the strobed lanes of a write into a byte-swapped register.
	function automatic logic [31:0] bmc_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] nw;
		logic [31:0] sw;
		nw = old;
		sw = bmc_swap(wd);
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				nw[31-8*i -: 8] = sw[31-8*i -: 8];
		end
		bmc_merge = nw;
	endfunction : bmc_merge

	// True for the comparator registers that the arm flag locks against writes.
	function automatic logic bmc_is_cfg(input logic [11:0] a);
		bmc_is_cfg = (a == BMC_OFF_A_DATA) || (a == BMC_OFF_A_MASK) ||
			(a == BMC_OFF_B_CTRL) || (a == BMC_OFF_B_ADDR);
	endfunction : bmc_is_cfg

	bmc_state_t s_q;
	bmc_state_t s_d;

	logic        setup;
	logic        wr_acc;
	logic        mapped;
	logic [7:0]  cfg;
	logic        b_hit;
	logic        a_hit;
	logic [2:0]  events;
	logic [2:0]  clr;
	logic        refused;

	// APB phase decode; a write takes effect at the completing access edge.
	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pwrite && pclk_en;
	assign mapped = (paddr == BMC_OFF_A_DATA) || (paddr == BMC_OFF_A_MASK) ||
		(paddr == BMC_OFF_B_CTRL) || (paddr == BMC_OFF_B_ADDR) ||
		(paddr == BMC_OFF_STATUS) || (paddr == BMC_OFF_CLEAR) ||
		(paddr == BMC_OFF_ENABLE);

	// Range mode hands the configuration over to the comparator A control.
	assign cfg = range_pair_select ? comp_a_control : s_q.b_ctrl;

	// Comparator B: opcode address alone, or data address with optional direction.
	always_comb
	begin
		b_hit = 1'b0;
		if (cfg[BMC_CTL_INSTRUCTION_SELECT])
			b_hit = core_pc_valid && (core_pc == s_q.b_addr);
		else
			b_hit = core_acc_valid && (core_addr == s_q.b_addr) &&
				(!cfg[BMC_CTL_RWE] || (core_rw == cfg[BMC_CTL_RWV]));
		b_hit = b_hit && cfg[BMC_CTL_EN] && breakpoint_unit_arm;
	end

	// Comparator A data term: only mask-selected bits must equal the value bits.
	assign a_hit = breakpoint_unit_arm && core_acc_valid &&
		(((core_data ^ s_q.a_data) & s_q.a_mask) == 32'h0000_0000);

	// Events that set sticky status bits, and the bits that software clears.
	// Only a locked comparator register refuses a write; clear and enable stay writable.
	assign refused = wr_acc && breakpoint_unit_arm && bmc_is_cfg(paddr);
	assign events = {refused, b_hit, a_hit};
	assign clr    = (wr_acc && (paddr == BMC_OFF_CLEAR) && pstrb[0]) ? pwdata[2:0] : 3'h0;

	// Next state: register writes, status, matches and the read data of the next access.
	always_comb
	begin
		s_d = s_q;
		if (pclk_en)
		begin
			s_d.match_a = a_hit;
			s_d.match_b = b_hit;
			s_d.status  = (s_q.status & ~clr) | events;
			if (wr_acc && !breakpoint_unit_arm)
			begin
				case (paddr)
					BMC_OFF_A_DATA: s_d.a_data = bmc_merge(s_q.a_data, pwdata, pstrb);
					BMC_OFF_A_MASK: s_d.a_mask = bmc_merge(s_q.a_mask, pwdata, pstrb);
					BMC_OFF_B_CTRL:
					begin
						if (pstrb[0])
							s_d.b_ctrl = pwdata[7:0] & BMC_CTL_WMASK;
					end
					BMC_OFF_B_ADDR:
					begin
						for (int i = 0; i < 3; i++)
						begin
							if (pstrb[i])
								s_d.b_addr[8*i +: 8] = pwdata[8*i +: 8];
						end
					end
					default: s_d.b_addr = s_q.b_addr;
				endcase
			end
			if (wr_acc && (paddr == BMC_OFF_ENABLE) && pstrb[0])
				s_d.irq_en = pwdata[2:0];
			if (setup)
			begin
				s_d.err = !mapped;
				case (paddr)
					BMC_OFF_A_DATA: s_d.rdata = bmc_swap(s_q.a_data);
					BMC_OFF_A_MASK: s_d.rdata = bmc_swap(s_q.a_mask);
					BMC_OFF_B_CTRL: s_d.rdata = {24'h00_0000, s_q.b_ctrl};
					BMC_OFF_B_ADDR: s_d.rdata = {8'h00, s_q.b_addr};
					BMC_OFF_STATUS: s_d.rdata = {29'h0000_0000, s_q.status};
					BMC_OFF_ENABLE: s_d.rdata = {29'h0000_0000, s_q.irq_en};
					default:        s_d.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// State register with asynchronous reset to constants.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q.a_data  <= BMC_RST_A_DATA;
			s_q.a_mask  <= BMC_RST_A_MASK;
			s_q.b_ctrl  <= BMC_RST_B_CTRL;
			s_q.b_addr  <= BMC_RST_B_ADDR;
			s_q.status  <= BMC_RST_EVENTS;
			s_q.irq_en  <= BMC_RST_EVENTS;
			s_q.match_a <= 1'b0;
			s_q.match_b <= 1'b0;
			s_q.rdata   <= 32'h0000_0000;
			s_q.err     <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// Outputs; the access phase completes in its first cycle unless the clock is held.
	assign pready            = pclk_en;
	assign prdata            = s_q.rdata;
	assign pslverr           = s_q.err && psel && penable;
	assign comp_a_data_match = s_q.match_a;
	assign comp_b_match      = s_q.match_b;
	assign irq               = |(s_q.status & s_q.irq_en);

	// Checks on the logic above.
	default clocking bmc_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_armed_write_ignored: assert property (
		(wr_acc && breakpoint_unit_arm) |=> $stable(s_q.a_data) && $stable(s_q.b_ctrl))
		else $error("Register changed by a write while armed.");

	a_data_byte_order: assert property (
		(wr_acc && !breakpoint_unit_arm && paddr == BMC_OFF_A_DATA && pstrb == 4'h1)
		|=> s_q.a_data[31:24] == $past(pwdata[7:0]) && s_q.a_data[23:0] == $past(s_q.a_data[23:0]))
		else $error("Lowest data byte did not land in bits 31 to 24.");

	a_mask_byte_order: assert property (
		(wr_acc && !breakpoint_unit_arm && paddr == BMC_OFF_A_MASK && pstrb == 4'h8)
		|=> s_q.a_mask[7:0] == $past(pwdata[31:24]))
		else $error("Highest mask byte did not land in bits 7 to 0.");

	a_ctrl_reserved_zero: assert property (
		(pclk_en && setup && !pwrite && paddr == BMC_OFF_B_CTRL)
		|=> (prdata[7:6] == 2'b00) && !prdata[4] && !prdata[1])
		else $error("Reserved control bits read as one.");

	a_b_disabled_quiet: assert property (
		(pclk_en && !cfg[BMC_CTL_EN]) |=> !comp_b_match)
		else $error("Disabled comparator B matched.");

	a_b_opcode_match: assert property (
		(pclk_en && breakpoint_unit_arm && cfg[BMC_CTL_EN] && cfg[BMC_CTL_INSTRUCTION_SELECT] &&
		core_pc_valid && core_pc == s_q.b_addr && core_rw != cfg[BMC_CTL_RWV]) |=> comp_b_match)
		else $error("Opcode address match missed.");

	a_b_dir_mismatch: assert property (
		(pclk_en && !cfg[BMC_CTL_INSTRUCTION_SELECT] && cfg[BMC_CTL_RWE] && core_rw != cfg[BMC_CTL_RWV])
		|=> !comp_b_match)
		else $error("Match despite wrong bus direction.");

	a_b_addr_needed: assert property (
		(pclk_en && !cfg[BMC_CTL_INSTRUCTION_SELECT] && core_addr != s_q.b_addr) |=> !comp_b_match)
		else $error("Match despite differing address.");

	a_a_unmasked_hit: assert property (
		(pclk_en && breakpoint_unit_arm && core_acc_valid && s_q.a_mask == 32'h0000_0000)
		|=> comp_a_data_match)
		else $error("All-masked data comparison did not match.");

	a_disarmed_quiet: assert property (
		(pclk_en && !breakpoint_unit_arm) |=> !comp_a_data_match && !comp_b_match)
		else $error("Match while disarmed.");

	a_event_sticky: assert property (
		(pclk_en && b_hit) |=> s_q.status[BMC_EV_B_MATCH] ##1 (s_q.status[BMC_EV_B_MATCH] || clr != 3'h0 || $past(clr) != 3'h0))
		else $error("Comparator B event not held.");

	// A refused write leaves its mark in the status register.
	a_refused_flag: assert property (
		refused |=> s_q.status[BMC_EV_REFUSED])
		else $error("Refused write did not set its status bit.");

	// A low clock enable freezes every register of the block.
	a_freeze_state: assert property (
		!pclk_en |=> $stable(s_q))
		else $error("State changed while the clock enable was low.");

	// A full mask write lands with the lowest byte on top.
	a_mask_full_write: assert property (
		(wr_acc && !breakpoint_unit_arm && paddr == BMC_OFF_A_MASK && pstrb == 4'hf)
		|=> s_q.a_mask == {$past(pwdata[7:0]), $past(pwdata[15:8]),
		$past(pwdata[23:16]), $past(pwdata[31:24])})
		else $error("Mask word landed in the wrong byte order.");

	// A full address write lands as written.
	a_b_addr_write: assert property (
		(wr_acc && !breakpoint_unit_arm && paddr == BMC_OFF_B_ADDR && pstrb == 4'h7)
		|=> s_q.b_addr == $past(pwdata[23:0]))
		else $error("Comparator B address write lost.");

	// A data access of the selected direction at the stored address matches.
	a_b_dir_match: assert property (
		(pclk_en && breakpoint_unit_arm && cfg[BMC_CTL_EN] && !cfg[BMC_CTL_INSTRUCTION_SELECT] &&
		cfg[BMC_CTL_RWE] && core_acc_valid && core_addr == s_q.b_addr &&
		core_rw == cfg[BMC_CTL_RWV]) |=> comp_b_match)
		else $error("Data access match with right direction missed.");

	// A selected data bit that differs prevents the data match.
	a_a_masked_miss: assert property (
		(pclk_en && (((core_data ^ s_q.a_data) & s_q.a_mask) != 32'h0000_0000))
		|=> !comp_a_data_match)
		else $error("Data match despite a differing selected bit.");

	// In range mode a disabled comparator A control keeps comparator B quiet.
	a_range_cfg_used: assert property (
		(pclk_en && range_pair_select && !comp_a_control[BMC_CTL_EN]) |=> !comp_b_match)
		else $error("Range mode ignored the comparator A control.");

	// With instruction select set, another opcode address never matches.
	a_pc_exact_only: assert property (
		(pclk_en && cfg[BMC_CTL_INSTRUCTION_SELECT] && core_pc != s_q.b_addr) |=> !comp_b_match)
		else $error("Opcode match on a different address.");

	// A comparator B hit always sets its status bit, even against a clear.
	a_set_beats_clear: assert property (
		(pclk_en && b_hit) |=> s_q.status[BMC_EV_B_MATCH])
		else $error("Clear won over a comparator B event.");

	// A read of the comparator B address returns it in the low three bytes.
	a_b_addr_read: assert property (
		(pclk_en && setup && paddr == BMC_OFF_B_ADDR) |=> prdata == {8'h00, $past(s_q.b_addr)})
		else $error("Comparator B address read back wrong.");

	// The interrupt is high while the comparator B status bit is set and enabled.
	a_irq_level: assert property (
		(s_q.status[BMC_EV_B_MATCH] && s_q.irq_en[BMC_EV_B_MATCH]) |-> irq)
		else $error("Interrupt low with an enabled status bit set.");

	c_data_write: cover property (wr_acc && !breakpoint_unit_arm && paddr == BMC_OFF_A_DATA);
	c_b_match: cover property (comp_b_match);
	c_range_mode: cover property (range_pair_select && comp_b_match);
	c_irq: cover property (irq);
	c_refused: cover property (refused);

endmodule : bmc_bus_match_comparator_regs

// ==== bmc_core_model.sv ====
// Behavioural model of the processor core bus that feeds the comparators.
`timescale 1ns/100ps
module bmc_core_model
(
	// Clock of the core bus.
	input  wire logic        pclk,
	// Core bus driven towards the comparators.
	output logic             core_acc_valid,
	output logic             core_pc_valid,
	output logic      [23:0] core_addr,
	output logic      [23:0] core_pc,
	output logic      [31:0] core_data,
	output logic             core_rw
);
	// The bus is idle at time zero.
	initial
	begin
		{core_acc_valid, core_pc_valid, core_rw} = 3'h0;
		{core_addr, core_pc, core_data} = 80'h0;
	end

	// One bus cycle; afterwards the released lines show inverted values, not stale ones.
	task automatic bus_cycle(input logic av, pv, input logic [23:0] a,
		input logic [31:0] d, input logic rw);
		@(posedge pclk);
		{core_acc_valid, core_pc_valid, core_rw} <= {av, pv, rw};
		{core_addr, core_pc, core_data} <= {a, a, d};
		@(posedge pclk);
		{core_acc_valid, core_pc_valid, core_rw} <= {2'h0, ~rw};
		{core_addr, core_pc, core_data} <= {~a, ~a, ~d};
	endtask : bus_cycle
endmodule : bmc_core_model

// ==== tb_bmc_bus_match_comparator_regs.sv ====
// Self-checking testbench of the bus match comparator register block.
`timescale 1ns/100ps
module tb_bmc_bus_match_comparator_regs
	import bmc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, pclk_en;
	logic        breakpoint_unit_arm, range_pair_select, core_acc_valid, core_pc_valid;
	logic        core_rw, comp_a_data_match, comp_b_match, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, core_data;
	logic [3:0]  pstrb;
	logic [7:0]  comp_a_control;
	logic [23:0] core_addr, core_pc;
	int          n_errors, n_compared, cyc;

	// Design and core bus model.
	bmc_bus_match_comparator_regs u_bmc_bus_match_comparator_regs (.pclk(pclk),
		.presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .breakpoint_unit_arm(breakpoint_unit_arm),
		.range_pair_select(range_pair_select), .comp_a_control(comp_a_control),
		.core_acc_valid(core_acc_valid), .core_addr(core_addr), .core_data(core_data),
		.core_rw(core_rw), .core_pc_valid(core_pc_valid), .core_pc(core_pc),
		.comp_a_data_match(comp_a_data_match), .comp_b_match(comp_b_match), .irq(irq));
	bmc_core_model u_bmc_core_model (.pclk(pclk), .core_acc_valid(core_acc_valid),
		.core_pc_valid(core_pc_valid), .core_addr(core_addr), .core_pc(core_pc),
		.core_data(core_data), .core_rw(core_rw));

	// Clock of 50 ns period.
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Hang guard: running out of cycles counts as a mismatch.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
			$display("CHECK FAILED %0t saw %h wanted %h", $time, seen, exp);
		if (seen !== exp)
			n_errors++;
	endtask : chk

	// One APB transfer; read data and error are taken at the edge where pready is high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask : apb

	task automatic set_arm(input logic v);
		@(posedge pclk);
		breakpoint_unit_arm <= v;
	endtask : set_arm

	// One core bus cycle, then both match outputs are compared.
	task automatic core(input logic av, pv, input logic [23:0] a, input logic [31:0] d,
		input logic rw, ea, eb);
		u_bmc_core_model.bus_cycle(av, pv, a, d, rw);
		#1;
		chk(comp_a_data_match, ea);
		chk(comp_b_match, eb);
	endtask : core

	task automatic t_bytes;
		apb(1'b0, BMC_OFF_B_CTRL, 32'h0, 4'hf);
		chk(rd, 32'h0);
		apb(1'b1, BMC_OFF_A_MASK, 32'hff, 4'h1);
		apb(1'b1, BMC_OFF_A_DATA, 32'h5a, 4'h1);
		apb(1'b0, BMC_OFF_A_DATA, 32'h0, 4'hf);
		chk(rd, 32'h5a);
		core(1'b1, 1'b0, 24'h0, 32'h5a00_0000, 1'b0, 1'b0, 1'b0);
		set_arm(1'b1);
		core(1'b1, 1'b0, 24'h0, 32'h5a12_3456, 1'b0, 1'b1, 1'b0);
		core(1'b1, 1'b0, 24'h0, 32'h5b00_0000, 1'b0, 1'b0, 1'b0);
		core(1'b1, 1'b0, 24'h0, 32'h0000_005a, 1'b0, 1'b0, 1'b0);
		set_arm(1'b0);
	endtask : t_bytes

	// Each entry is {access, opcode, direction, address bit 23 wrong, expected match}.
	task automatic t_comp_b;
		logic [7:0] ctl [9] = '{8'h0d, 8'h0d, 8'h05, 8'h05, 8'h01, 8'h00, 8'h0d, 8'h2d, 8'h2d};
		logic [4:0] cs [9] = '{5'h15, 5'h10, 5'h11, 5'h14, 5'h11, 5'h14, 5'h16, 5'h09, 5'h14};
		apb(1'b1, BMC_OFF_B_CTRL, 32'hff, 4'h1);
		apb(1'b0, BMC_OFF_B_CTRL, 32'h0, 4'hf);
		chk(rd, 32'h2d);
		apb(1'b1, BMC_OFF_B_ADDR, 32'h12_3456, 4'h7);
		apb(1'b0, BMC_OFF_B_ADDR, 32'h0, 4'hf);
		chk(rd, 32'h12_3456);
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b1, BMC_OFF_B_CTRL, {24'h0, ctl[i]}, 4'h1);
			set_arm(1'b1);
			core(cs[i][4], cs[i][3], {cs[i][1], 23'h12_3456}, 32'h0, cs[i][2], 1'b0, cs[i][0]);
			set_arm(1'b0);
		end
	endtask : t_comp_b

	task automatic t_armed_range;
		apb(1'b1, BMC_OFF_B_CTRL, 32'h0d, 4'h1);
		set_arm(1'b1);
		apb(1'b1, BMC_OFF_B_ADDR, 32'hff_ffff, 4'h7);
		apb(1'b0, BMC_OFF_B_ADDR, 32'h0, 4'hf);
		chk(rd, 32'h12_3456);
		range_pair_select <= 1'b1;
		core(1'b1, 1'b0, 24'h12_3456, 32'h0, 1'b1, 1'b0, 1'b0);
		comp_a_control <= 8'h01;
		core(1'b1, 1'b0, 24'h12_3456, 32'h0, 1'b0, 1'b0, 1'b1);
		range_pair_select <= 1'b0;
		set_arm(1'b0);
	endtask : t_armed_range

	// Status set, masked, re-enabled and cleared; refused write and unmapped read.
	task automatic t_irq;
		apb(1'b1, BMC_OFF_CLEAR, 32'h7, 4'h1);
		apb(1'b1, BMC_OFF_ENABLE, 32'h2, 4'h1);
		set_arm(1'b1);
		core(1'b1, 1'b0, 24'h12_3456, 32'h0, 1'b1, 1'b0, 1'b1);
		chk(irq, 1'b1);
		apb(1'b1, BMC_OFF_ENABLE, 32'h0, 4'h1);
		#1 chk(irq, 1'b0);
		apb(1'b1, BMC_OFF_A_DATA, 32'h0, 4'hf);
		apb(1'b1, BMC_OFF_ENABLE, 32'h2, 4'h1);
		#1 chk(irq, 1'b1);
		apb(1'b1, BMC_OFF_CLEAR, 32'h2, 4'h1);
		#1 chk(irq, 1'b0);
		apb(1'b0, BMC_OFF_STATUS, 32'h0, 4'hf);
		chk(rd, 32'h4);
		apb(1'b0, 12'h200, 32'h0, 4'hf);
		chk({rd[30:0], err}, 32'h1);
		set_arm(1'b0);
	endtask : t_irq

	// All-zero mask matches any data; a low clock enable freezes the outputs.
	task automatic t_freeze;
		apb(1'b1, BMC_OFF_A_MASK, 32'h0, 4'hf);
		set_arm(1'b1);
		core(1'b1, 1'b0, 24'h0, 32'h1234_5678, 1'b0, 1'b1, 1'b0);
		@(posedge pclk);
		pclk_en <= 1'b0;
		core(1'b1, 1'b0, 24'h12_3456, 32'h0, 1'b1, 1'b0, 1'b0);
		chk(pready, 1'b0);
		@(posedge pclk);
		pclk_en <= 1'b1;
		set_arm(1'b0);
	endtask : t_freeze

	task automatic print_verdict;
		if (n_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// Reset for 12 cycles, then the scenarios.
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = 52'h0;
		{breakpoint_unit_arm, range_pair_select, comp_a_control} = 10'h0;
		pclk_en = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_bytes();
		t_comp_b();
		t_armed_range();
		t_irq();
		t_freeze();
		print_verdict();
	end
endmodule : tb_bmc_bus_match_comparator_regs
